//--- rtl/dac_port_pkg.sv
// ============================================================
// Shared constants for the serial command port
// ============================================================
// Notes on behaviour
// [R1] Sample data on rising serial clock while selected.
// [R2] No data bits taken while select high.
// [R3] Select rising ends transfer, executes word.
// [R4] Words are 24 or 32 bits.
// [R5] Command byte, two data bytes, optional check.
// [R6] Check only on 32-bit words.
// [R7] Cascaded host clocks multiples of 32.
// [R8] Count bits; fault on invalid length.
// [R9] Write word echoed during next transfer.
// [R10] 32-bit read returns command then data.
// [R11] 24-bit read returns data, first byte ignored.
// [R12] No write echo for 24-bit words.
// [R13] Reset: ranges 0-5 V, codes zero.
// [R14] Host issues software reset first.
// [R15] Output changes on falling clock, released when idle.
// [R16] Low command nibble is channel address.
// [R17] Most significant bit first.
package dac_port_pkg;
    localparam int unsigned WORD_SHORT   = 24;
    localparam int unsigned WORD_LONG    = 32;
    localparam int unsigned CNT_W        = 6;
    localparam int unsigned CHANNELS     = 8;
    localparam logic [3:0]  SPAN_DEFAULT = 4'h0;
    localparam logic [15:0] CODE_DEFAULT = 16'h0000;
    localparam logic [7:0]  CMD_SW_RESET = 8'h7F;
    localparam logic [7:0]  CMD_NOP      = 8'hFF;
    localparam logic [3:0]  OP_WR_CODE   = 4'h0;
    localparam logic [3:0]  OP_WR_SPAN   = 4'h1;
    localparam logic [3:0]  OP_RD_CODE   = 4'h8;
    localparam logic [3:0]  OP_RD_SPAN   = 4'h9;
    localparam int unsigned CRC_W        = 6;
    localparam int unsigned CLK_DIV      = 4;
    localparam int unsigned DIV_W        = 2;
endpackage

//--- rtl/dac_port_if.sv
`timescale 1ns/1ps
// ============================================================
// Serial link between host controller and converter port
// ============================================================
interface dac_port_if;
    logic chip_select_load_n;   // Select, low during a transfer.
    logic sclk;                 // Serial clock from host.
    logic mosi;                 // Host to device data.
    logic miso;                 // Device data bit.
    logic miso_oe_n;            // Low while device drives data.
    modport host   (output chip_select_load_n, output sclk, output mosi,
                    input miso, input miso_oe_n);
    modport device (input chip_select_load_n, input sclk, input mosi,
                    output miso, output miso_oe_n);
endinterface

//--- rtl/dac_port_device.sv
`timescale 1ns/1ps
// ============================================================
// Device end: shifts, counts, executes and answers
// ============================================================
module dac_port_device
    import dac_port_pkg::*;
(
    input  wire logic        CLK_IN,        // System clock, 100 MHz.
    input  wire logic        RESET_IN,      // Synchronous reset, high.
    dac_port_if.device       LINK,          // Serial link.
    output logic             EXEC_OUT,      // One-cycle pulse per executed word.
    output logic [31:0]      WORD_OUT,      // Last executed word, left aligned.
    output logic             LONG_OUT,      // Last word was 32 bits.
    output logic             FAULT_OUT,     // Sticky bad-length fault.
    output logic [3:0]       CHAN_OUT,      // Channel address of last word.
    output logic [127:0]     CODES_OUT,     // Eight 16-bit channel codes.
    output logic [31:0]      SPANS_OUT      // Eight 4-bit channel spans.
);
    // ============================================================
    // Pin synchronisers
    // ============================================================
    logic [2:0] cs_s_q, ck_s_q, dq_s_q;
    logic [2:0] cs_s_d, ck_s_d, dq_s_d;
    // Two flops per pin, a third stage only for edge detection.
    always_comb begin
        cs_s_d = {cs_s_q[1:0], LINK.chip_select_load_n};
        ck_s_d = {ck_s_q[1:0], LINK.sclk};
        dq_s_d = {dq_s_q[1:0], LINK.mosi};
    end
    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            cs_s_q <= 3'h7;
            ck_s_q <= 3'h0;
            dq_s_q <= 3'h0;
        end else begin
            cs_s_q <= cs_s_d;
            ck_s_q <= ck_s_d;
            dq_s_q <= dq_s_d;
        end
    end
    logic sel, ck_rise, ck_fall, cs_rise, cs_fall;
    assign sel     = ~cs_s_q[1];
    assign ck_rise = ck_s_q[1] & ~ck_s_q[2];
    assign ck_fall = ~ck_s_q[1] & ck_s_q[2];
    assign cs_rise = cs_s_q[1] & ~cs_s_q[2];
    assign cs_fall = ~cs_s_q[1] & cs_s_q[2];

    function automatic logic [CNT_W-1:0] inc_sat(input logic [CNT_W-1:0] v);
        inc_sat = (v == {CNT_W{1'b1}}) ? v : v + 1'b1;
    endfunction

    // ============================================================
    // Shifting, counting and execution
    // ============================================================
    logic [31:0]      shift_q, shift_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [31:0]      out_q, out_d;
    logic [31:0]      reply_q, reply_d;
    logic             miso_q, miso_d;
    logic             oe_n_q, oe_n_d;
    logic             exec_q, exec_d, long_q, long_d, fault_q, fault_d;
    logic [31:0]      word_q, word_d;
    logic [15:0]      code_q [CHANNELS];
    logic [15:0]      code_d [CHANNELS];
    logic [3:0]       span_q [CHANNELS];
    logic [3:0]       span_d [CHANNELS];
    logic [31:0]      w;
    logic [2:0]       ch;

    // Next-state of the whole serial engine.
    always_comb begin
        shift_d = shift_q;
        cnt_d   = cnt_q;
        out_d   = out_q;
        reply_d = reply_q;
        miso_d  = miso_q;
        oe_n_d  = oe_n_q;
        exec_d  = 1'b0;
        long_d  = long_q;
        fault_d = fault_q;
        word_d  = word_q;
        code_d  = code_q;
        span_d  = span_q;
        w       = 32'h0;
        ch      = 3'h0;
        if (cs_fall) begin
            // Load the pending reply and present its first bit at once. [R15]
            cnt_d  = '0;
            out_d  = {reply_q[30:0], 1'b0};
            miso_d = reply_q[31];               // [R17]
            oe_n_d = 1'b0;
        end else if (sel && ck_rise) begin
            shift_d = {shift_q[30:0], dq_s_q[1]}; // [R1] [R17]
            cnt_d   = inc_sat(cnt_q);           // [R8]
        end else if (sel && ck_fall) begin
            miso_d = out_q[31];                 // [R15]
            out_d  = {out_q[30:0], 1'b0};
        end
        if (cs_rise) begin
            oe_n_d  = 1'b1;                     // [R15]
            reply_d = 32'h0;
            // Bits arriving with select high never reach the shifter. [R2]
            if (cnt_q == CNT_W'(WORD_LONG) || cnt_q == CNT_W'(WORD_SHORT)) begin // [R4]
                long_d = (cnt_q == CNT_W'(WORD_LONG));
                // Align short words to the top; check field sits in low byte. [R5]
                w = long_d ? shift_q : {shift_q[23:0], 8'h00};
                exec_d = 1'b1;                  // [R3]
                word_d = w;
                // Check field is passed on only for long words. [R6]
                if (!long_d) word_d[7:0] = 8'h00;
                ch = w[27:25];                  // [R16]
                if (w[31:24] == CMD_SW_RESET) begin
                    for (int i = 0; i < CHANNELS; i++) begin
                        code_d[i] = CODE_DEFAULT;
                        span_d[i] = SPAN_DEFAULT;
                    end
                    fault_d = 1'b0;
                end else if (w[31:28] == OP_WR_CODE) begin
                    code_d[ch] = w[23:8];
                end else if (w[31:28] == OP_WR_SPAN) begin
                    span_d[ch] = w[11:8];
                end
                if (w[31]) begin
                    // Reads: long words echo the command, short ones leave it zero.
                    reply_d[31:24] = long_d ? w[31:24] : 8'h00; // [R10] [R11]
                    if (w[30:28] == OP_RD_SPAN[2:0])
                        reply_d[23:8] = {12'h000, span_q[ch]};
                    else
                        reply_d[23:8] = code_q[ch];
                end else if (long_d) begin
                    reply_d = w;                // [R9] [R12]
                end
            end else begin
                fault_d = 1'b1;                 // [R8]
            end
        end
    end

    // Reset restores defaults for every channel. [R13]
    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            shift_q <= 32'h0;
            cnt_q   <= '0;
            out_q   <= 32'h0;
            reply_q <= 32'h0;
            miso_q  <= 1'b0;
            oe_n_q  <= 1'b1;
            exec_q  <= 1'b0;
            long_q  <= 1'b0;
            fault_q <= 1'b0;
            word_q  <= 32'h0;
            for (int i = 0; i < CHANNELS; i++) begin
                code_q[i] <= CODE_DEFAULT;      // [R13]
                span_q[i] <= SPAN_DEFAULT;
            end
        end else begin
            shift_q <= shift_d;
            cnt_q   <= cnt_d;
            out_q   <= out_d;
            reply_q <= reply_d;
            miso_q  <= miso_d;
            oe_n_q  <= oe_n_d;
            exec_q  <= exec_d;
            long_q  <= long_d;
            fault_q <= fault_d;
            word_q  <= word_d;
            code_q  <= code_d;
            span_q  <= span_d;
        end
    end

    // ============================================================
    // Outputs
    // ============================================================
    assign LINK.miso      = miso_q;
    assign LINK.miso_oe_n = oe_n_q;
    assign EXEC_OUT       = exec_q;
    assign WORD_OUT       = word_q;
    assign LONG_OUT       = long_q;
    assign FAULT_OUT      = fault_q;
    assign CHAN_OUT       = word_q[27:24];
    // Flatten arrays for the port; the address maps channel n to bits A3..A1.
    always_comb begin
        for (int i = 0; i < CHANNELS; i++) begin
            CODES_OUT[i*16 +: 16] = code_q[i];
            SPANS_OUT[i*4 +: 4]   = span_q[i];
        end
    end
endmodule

//--- rtl/dac_port_host.sv
`timescale 1ns/1ps
// ============================================================
// Host end: sends one word per request, returns what came back
// ============================================================
module dac_port_host
    import dac_port_pkg::*;
(
    input  wire logic        CLK_IN,        // System clock, 100 MHz.
    input  wire logic        RESET_IN,      // Synchronous reset, high.
    dac_port_if.host         LINK,          // Serial link.
    input  wire logic        REQ_IN,        // Start a transfer, taken when ready.
    input  wire logic        LONG_IN,       // 1 sends 32 bits, 0 sends 24.
    input  wire logic [31:0] WORD_IN,       // Word, left aligned.
    output logic             READY_OUT,     // Idle, may take a request.
    output logic             DONE_OUT,      // One-cycle pulse at end.
    output logic [31:0]      RX_OUT         // Bits received, left aligned.
);
    typedef enum logic [1:0] {IDLE, LEAD, SHIFT, TAIL} state_e;
    state_e           st_q, st_d;
    logic [DIV_W-1:0] div_q, div_d;
    logic [CNT_W-1:0] n_q, n_d, len_q, len_d;
    logic [31:0]      tx_q, tx_d, rx_q, rx_d;
    logic             ck_q, ck_d, cs_q, cs_d, done_q, done_d;
    logic [1:0]       rs_q, rs_d;
    logic             tick;

    // Divider gives the half-period enable of the serial clock.
    assign tick = (div_q == DIV_W'(CLK_DIV - 1));

    // Host walks the select low for every bit it clocks. [R2] [R17]
    // Reply bits are taken just before each falling edge: the device moves its
    // output a few cycles after a fall, so the new bit has settled well before the next fall.
    always_comb begin
        st_d   = st_q;
        div_d  = tick ? '0 : div_q + 1'b1;
        n_d    = n_q;
        len_d  = len_q;
        tx_d   = tx_q;
        rx_d   = rx_q;
        ck_d   = ck_q;
        cs_d   = cs_q;
        done_d = 1'b0;
        rs_d   = {rs_q[0], LINK.miso};
        case (st_q)
            IDLE: begin
                if (REQ_IN) begin
                    // A cascade would need multiples of 32; single device here. [R7]
                    len_d = LONG_IN ? CNT_W'(WORD_LONG) : CNT_W'(WORD_SHORT); // [R4]
                    tx_d  = WORD_IN;
                    n_d   = '0;
                    cs_d  = 1'b0;
                    div_d = '0;
                    st_d  = LEAD;
                end
            end
            LEAD: if (tick) st_d = SHIFT;
            SHIFT: if (tick) begin
                if (!ck_q) begin
                    ck_d = 1'b1;
                    n_d  = n_q + 1'b1;
                end else begin
                    ck_d = 1'b0;
                    rx_d = {rx_q[30:0], rs_q[1]};   // [R17]
                    tx_d = {tx_q[30:0], 1'b0};
                    if (n_q == len_q) st_d = TAIL;
                end
            end
            default: if (tick) begin
                cs_d   = 1'b1;
                done_d = 1'b1;
                st_d   = IDLE;                      // [R3]
            end
        endcase
    end

    // Registers only; reset leaves select high and the serial clock low.
    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            st_q   <= IDLE;
            div_q  <= '0;
            n_q    <= '0;
            len_q  <= '0;
            tx_q   <= 32'h0;
            rx_q   <= 32'h0;
            ck_q   <= 1'b0;
            cs_q   <= 1'b1;
            done_q <= 1'b0;
            rs_q   <= 2'h0;
        end else begin
            st_q   <= st_d;
            div_q  <= div_d;
            n_q    <= n_d;
            len_q  <= len_d;
            tx_q   <= tx_d;
            rx_q   <= rx_d;
            ck_q   <= ck_d;
            cs_q   <= cs_d;
            done_q <= done_d;
            rs_q   <= rs_d;
        end
    end

    assign LINK.chip_select_load_n = cs_q;
    assign LINK.sclk               = ck_q;
    assign LINK.mosi               = tx_q[31];
    assign READY_OUT               = (st_q == IDLE);
    assign DONE_OUT                = done_q;
    // Short replies are read with the first byte ignored by the user. [R11]
    assign RX_OUT = (len_q == CNT_W'(WORD_SHORT)) ? {rx_q[23:0], 8'h00} : rx_q;
endmodule

//--- test/dac_port_checker.sv
`timescale 1ns/1ps
// ============================================================
// Link checker: framing and timing seen on the serial wires
// ============================================================
module dac_port_checker
    import dac_port_pkg::*;
(
    input  wire logic CLK_IN,             // System clock.
    input  wire logic RESET_IN,           // Synchronous reset, high.
    input  wire logic chip_select_load_n, // Select, low active.
    input  wire logic sclk,               // Serial clock.
    input  wire logic mosi,               // Host data.
    input  wire logic miso,               // Device data.
    input  wire logic miso_oe_n           // Device drive enable, low active.
);
    logic       sclk_q;
    logic [5:0] edges_q;
    logic [5:0] edges_d;
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (RESET_IN);
    // Rising serial edges per frame; cleared while idle so each frame starts at zero.
    always_comb begin
        edges_d = edges_q;
        if (chip_select_load_n) edges_d = 6'h00;
        else if (sclk && !sclk_q) edges_d = edges_q + 6'h01;
    end
    // Registers for the edge count.
    always_ff @(posedge CLK_IN) begin
        sclk_q  <= RESET_IN ? 1'b0 : sclk;
        edges_q <= RESET_IN ? 6'h00 : edges_d;
    end
    // Frame start is select falling, then a quiet low clock for setup.
    sequence s_select; $fell(chip_select_load_n); endsequence
    sequence s_setup; !sclk [*3]; endsequence
    property p_start; s_select |-> s_setup; endproperty
    property p_len; $rose(chip_select_load_n) |-> edges_q == 6'(WORD_SHORT) || edges_q == 6'(WORD_LONG); endproperty
    property p_idle; chip_select_load_n |-> !sclk; endproperty
    property p_end; $rose(chip_select_load_n) |-> !$past(sclk); endproperty
    property p_oe; chip_select_load_n [*8] |-> miso_oe_n; endproperty
    property p_miso; !miso_oe_n && $changed(miso) |-> !sclk; endproperty
    property p_mosi; sclk && $past(sclk) |-> $stable(mosi); endproperty
    property p_high; $rose(sclk) |-> sclk [*3]; endproperty
    property p_bound; $rose(sclk) |-> ##[1:8] !sclk; endproperty
    a_start: assert property (p_start) else $error("clock rose too soon");
    a_len: assert property (p_len) else $error("bad frame length");
    a_idle: assert property (p_idle) else $error("clock while idle");
    a_end: assert property (p_end) else $error("select rose with clock high");
    a_oe: assert property (p_oe) else $error("data out not released");
    a_miso: assert property (p_miso) else $error("data out moved on high clock");
    a_mosi: assert property (p_mosi) else $error("data in moved on high clock");
    a_high: assert property (p_high) else $error("clock high too short");
    a_bound: assert property (p_bound) else $error("clock stuck high");
endmodule

//--- test/tb_dac_serial_command_port.sv
`timescale 1ns/1ps
// ============================================================
// Bench: host and device joined, a raw driver on a spare device
// ============================================================
module tb_dac_serial_command_port
    import dac_port_pkg::*;
;
    logic         clk, rst, req, long_in, ready, done, exec, long_o, fault, exec2, fault2;
    logic [31:0]  word_in, rx, word, spans;
    logic [3:0]   chan;
    logic [127:0] codes;
    int           n_fail, checks_done, n_exec, n_exec2;
    dac_port_if   lk();
    dac_port_if   lk2();
    dac_port_host u_dac_port_host (.CLK_IN(clk), .RESET_IN(rst), .LINK(lk), .REQ_IN(req),
        .LONG_IN(long_in), .WORD_IN(word_in), .READY_OUT(ready), .DONE_OUT(done), .RX_OUT(rx));
    dac_port_device u_dac_port_device (.CLK_IN(clk), .RESET_IN(rst), .LINK(lk),
        .EXEC_OUT(exec), .WORD_OUT(word), .LONG_OUT(long_o), .FAULT_OUT(fault),
        .CHAN_OUT(chan), .CODES_OUT(codes), .SPANS_OUT(spans));
    // The spare device lets the bench break the length rule the host never breaks.
    dac_port_device u_dac_port_device_raw (.CLK_IN(clk), .RESET_IN(rst), .LINK(lk2),
        .EXEC_OUT(exec2), .WORD_OUT(), .LONG_OUT(), .FAULT_OUT(fault2), .CHAN_OUT(),
        .CODES_OUT(), .SPANS_OUT());
    dac_port_checker u_dac_port_checker (.CLK_IN(clk), .RESET_IN(rst),
        .chip_select_load_n(lk.chip_select_load_n), .sclk(lk.sclk), .mosi(lk.mosi),
        .miso(lk.miso), .miso_oe_n(lk.miso_oe_n));
    // Clock at 100 MHz.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Execute pulses are counted so a missing or doubled one is seen.
    always @(posedge clk) begin
        if (exec === 1'b1) n_exec++;
        if (exec2 === 1'b1) n_exec2++;
    end
    // Wide enough for every code and span at once, so no bit is cut off.
    task automatic check(input logic [191:0] seen, input logic [191:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected at %0t: saw %0h, wanted %0h", $time, seen, exp);
        end
    endtask
    // One host transfer; request held until the edge where ready is seen.
    task automatic xfer(input logic lg, input logic [31:0] w);
        int k;
        k = 0;
        @(posedge clk);
        req <= 1'b1;
        long_in <= lg;
        word_in <= w;
        do @(posedge clk); while (ready !== 1'b1 && ++k < 50);
        req <= 1'b0;
        do @(posedge clk); while (done !== 1'b1 && ++k < 400);
        if (k >= 400) begin
            n_fail++;
            $display("unexpected at %0t: no done", $time);
        end
        repeat (8) @(posedge clk);
    endtask
    // Raw frame of n bits on the spare link, clock high for four cycles and low for five.
    task automatic raw(input int n, input logic [31:0] w);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            lk2.chip_select_load_n <= 1'b0;
            lk2.mosi <= w[31-i];
            repeat (4) @(posedge clk);
            lk2.sclk <= 1'b1;
            repeat (4) @(posedge clk);
            lk2.sclk <= 1'b0;
        end
        repeat (4) @(posedge clk);
        lk2.chip_select_load_n <= 1'b1;
        lk2.mosi <= ~lk2.mosi;
        repeat (8) @(posedge clk);
    endtask
    task automatic t_reset;
        int n;
        check({codes, spans, fault}, 161'h0);
        check(lk.miso_oe_n, 1'b1);
        n = n_exec;
        xfer(1'b0, {CMD_SW_RESET, 24'h0});
        check(n_exec, n + 1);
        $display("reset test done");
    endtask
    task automatic t_write;
        int n;
        n = n_exec;
        xfer(1'b1, 32'h02A5C32A);
        check(n_exec, n + 1);
        check(word, 32'h02A5C32A);
        check({long_o, chan, fault}, {1'b1, 4'h2, 1'b0});
        check(codes[31:16], 16'hA5C3);
        xfer(1'b1, {CMD_NOP, 24'h0});
        check(rx, 32'h02A5C32A);
        $display("long write test done");
    endtask
    task automatic t_short;
        xfer(1'b0, 32'h16000300);
        check({long_o, word}, {1'b0, 32'h16000300});
        check(spans[15:12], 4'h3);
        xfer(1'b0, {CMD_NOP, 24'h0});
        check(rx[31:8], 24'h0);
        xfer(1'b1, 32'h96000000);
        xfer(1'b1, {CMD_NOP, 24'h0});
        check(rx, 32'h96000300);
        $display("short write test done");
    endtask
    task automatic t_read;
        xfer(1'b1, 32'h82000000);
        xfer(1'b1, {CMD_NOP, 24'h0});
        check(rx[31:8], 24'h82A5C3);
        xfer(1'b0, 32'h82000000);
        xfer(1'b0, {CMD_NOP, 24'h0});
        check(rx[23:8], 16'hA5C3);
        xfer(1'b0, {CMD_SW_RESET, 24'h0});
        check({codes, spans}, 160'h0);
        $display("read test done");
    endtask
    task automatic t_bad_len;
        int n;
        n = n_exec2;
        raw(16, 32'h02FFFF00);
        check({fault2, 32'(n_exec2)}, {1'b1, 32'(n)});
        raw(24, {CMD_SW_RESET, 24'h0});
        check({fault2, 32'(n_exec2)}, {1'b0, 32'(n + 1)});
        $display("bad length test done");
    endtask
    task automatic tally_and_finish;
        $display("checks %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // About fifteen frames of under 300 cycles each; the limit leaves wide margin.
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        tally_and_finish;
    end
    // Main sequence.
    initial begin
        rst = 1'b1;
        req = 1'b0;
        long_in = 1'b0;
        word_in = 32'h0;
        lk2.chip_select_load_n = 1'b1;
        lk2.sclk = 1'b0;
        lk2.mosi = 1'b0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset;
        t_write;
        t_short;
        t_read;
        t_bad_len;
        tally_and_finish;
    end
endmodule
